/* File: pkg/cfpsb_defs.svh */
/*
  Constants of the core control block: data space offsets, status
  field positions, reset values, opcode encodings and register indices.
  Assumes it is included once per compilation unit by bare name.
*/
`ifndef CFPSB_DEFS_SVH
`define CFPSB_DEFS_SVH

// program space
`define CFPSB_PC_W 13
`define CFPSB_PC_RESET 13'h0000
`define CFPSB_IRQ_VECTOR 13'h0004

// data space, offsets within a bank
`define CFPSB_OFS_W 7
`define CFPSB_A_INDIRECT 7'h00
`define CFPSB_A_CNT_LOW 7'h02
`define CFPSB_A_STATUS 7'h03
`define CFPSB_A_UP_LATCH 7'h0A
`define CFPSB_SFR_LAST 7'h1F
`define CFPSB_COMMON_BASE 7'h70
`define CFPSB_B2_GPR_END 7'h50
`define CFPSB_BANK_2 2'h2

// status fields
`define CFPSB_ST_IND 7
`define CFPSB_ST_BHI 6
`define CFPSB_ST_BLO 5
`define CFPSB_ST_TMO 4
`define CFPSB_ST_PWD 3
`define CFPSB_ST_Z 2
`define CFPSB_ST_NC 1
`define CFPSB_ST_C 0
`define CFPSB_STATUS_RST 8'h18

// instruction encodings
`define CFPSB_BR_CALL 3'h4
`define CFPSB_BR_GOTO 3'h5
`define CFPSB_OPC_SPECIAL 6'h00
`define CFPSB_OPC_CLR 6'h01
`define CFPSB_OPC_SUB 6'h02
`define CFPSB_OPC_AND 6'h05
`define CFPSB_OPC_ADD 6'h07
`define CFPSB_OPC_MOV 6'h08
`define CFPSB_OPC_RRF 6'h0C
`define CFPSB_OPC_RLF 6'h0D
`define CFPSB_OPC_RETLIT 4'hD
`define CFPSB_SP_RETURN 7'h08
`define CFPSB_SP_RETINT 7'h09
`define CFPSB_SP_SLEEP 7'h63
`define CFPSB_SP_WDCLR 7'h64

// bus register indices, byte address is four times the index
`define CFPSB_REG_CTRL 2'h0
`define CFPSB_REG_PC 2'h1
`define CFPSB_REG_W 2'h2
`define CFPSB_REG_STATUS 2'h3
`define CFPSB_CTRL_RUN 0
`define CFPSB_CTRL_RST 1'b1

`endif

/* File: pkg/cfpsb_pkg.sv */
/*
  Types of the core control block: phase and decoded operation.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cfpsb_pkg;

  typedef enum logic [1:0] {
    PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR
  } cfpsb_phase_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_MOV, OP_CLR, OP_MOVWF, OP_RRF,
    OP_RLF, OP_GOTO, OP_CALL, OP_RET, OP_RETINT, OP_RETLIT, OP_SLEEP,
    OP_WDCLR
  } cfpsb_op_t;

endpackage : cfpsb_pkg
`default_nettype wire

/* File: hdl/cfpsb_phase_gen.sv */
/*
  Four-phase sequencer: divides sys_clk by four into binary-coded phases.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cfpsb_phase_gen
  import cfpsb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic run,
  // current phase
  output cfpsb_phase_t phase
);

  cfpsb_phase_t phase_r;
  cfpsb_phase_t phase_nxt;

  always_comb
  begin
    unique case (phase_r)
      PHASE_ONE: phase_nxt = PHASE_TWO;
      PHASE_TWO: phase_nxt = PHASE_THREE;
      PHASE_THREE: phase_nxt = PHASE_FOUR;
      PHASE_FOUR: phase_nxt = PHASE_ONE;
    endcase
  end

  // four input clocks make one instruction cycle [RQ1]
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      phase_r <= PHASE_ONE;
    else if (run)
      phase_r <= phase_nxt;
  end

  assign phase = phase_r;

endmodule : cfpsb_phase_gen
`default_nettype wire

/* File: hdl/cfpsb_ret_stack.sv */
/*
  Circular return stack, registered top of stack.
  Assumes push and pop never come in the same cycle and that DEPTH is a
  power of two, so the pointer wraps by itself.
*/
`timescale 1ns/10ps
`default_nettype none
module cfpsb_ret_stack
#(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 13
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [DW-1:0] push_data,
  output logic [DW-1:0] top_data
);

  logic [DW-1:0] mem_r [DEPTH];
  logic [AW-1:0] sp_r;
  logic [DW-1:0] top_r;
  wire logic [AW-1:0] top_idx = sp_r - AW'(1);

  // no overflow or underflow flag: the pointer simply wraps [RQ22]
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sp_r <= '0;
    else if (push)
      sp_r <= sp_r + AW'(1);
    else if (pop)
      sp_r <= top_idx;
  end

  // ninth push lands on the first entry [RQ22]
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[sp_r] <= push_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      top_r <= '0;
    else
      top_r <= mem_r[top_idx];
  end

  assign top_data = top_r;

endmodule : cfpsb_ret_stack
`default_nettype wire

/* File: hdl/cfpsb_core.sv */
/*
  Core control: four-phase sequencing, two-stage fetch/execute, program
  counter with upper latch, return stack, bank selection and status.
  Assumes program memory answers within one phase, the data file answers
  a read within phase two, and all inputs are on sys_clk.
*/
// Our own choice: the Avalon-MM register port.
// Overview of operation
// RQ1: input clock divided by four; four phases form one instruction cycle.
// RQ2: counter advances in phase one; fetched word latched in phase four.
// RQ3: fetch overlaps execute; counter-changing instructions cost two cycles.
// RQ4: operand read in phase two, destination written in phase four.
// RQ5: thirteen-bit counter addresses 8K words of fourteen bits.
// RQ6: addresses beyond implemented memory wrap into 1K or 2K region.
// RQ7: reset starts at address zero; interrupt vectors to address four.
// RQ8: two direct bank bits pick one of four data banks.
// RQ9: first 32 offsets per bank are special registers; listed ranges RAM.
// RQ10: top sixteen offsets of banks 1-3 mirror common RAM at 70h.
// RQ11: indirect bank bit picks banks 0-1 or banks 2-3.
// RQ12: status write skips zero and carry bits when flags are computed.
// RQ13: timeout flag set by power-up, watchdog clear or sleep; timeout clears.
// RQ14: power-down flag set by power-up or watchdog clear; cleared by sleep.
// RQ15: zero flag set when result is zero, cleared otherwise.
// RQ16: nibble carry is carry from low four bits; inverted borrow on subtract.
// RQ17: carry out of top bit; borrow inverted; rotate loads shifted-out bit.
// RQ18: status register sits at the same offset in every bank.
// RQ19: low byte write loads latch 4:0; branches take latch 4:3.
// RQ20: any reset clears the counter; upper bits not directly accessible.
// RQ21: eight 13-bit entries; push on call or interrupt, pop on returns.
// RQ22: stack is circular, ninth push overwrites first; no overflow flag.
`timescale 1ns/10ps
`default_nettype none
`include "cfpsb_defs.svh"
module cfpsb_core
  import cfpsb_pkg::*;
#(
  parameter int PMEM_AW = 10
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // avalon-mm register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // program memory
  output logic [12:0] prog_addr,
  input wire logic [13:0] prog_rdata,
  // banked data register file
  output logic [8:0] data_addr,
  output logic data_rd,
  output logic data_wr,
  output logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  input wire logic [7:0] indirect_pointer,
  output logic data_sfr_sel,
  output logic data_gpr_sel,
  // core events
  input wire logic irq_req,
  input wire logic wdt_timeout,
  output logic irq_ack,
  output logic wdt_clear,
  output logic sleep_req,
  output cfpsb_phase_t cur_phase
);

  localparam int PW = `CFPSB_PC_W;
  localparam int OW = `CFPSB_OFS_W;
  localparam logic [PW-1:0] PMASK = PW'((1 << PMEM_AW) - 1);

  function automatic logic [9:0] add_carry(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin);
    full = {1'b0, a} + {1'b0, b} + 9'(cin);
    return {lo[4], full};
  endfunction : add_carry

  function automatic logic [8:0] map_common(input logic [8:0] a);
    return (a[OW-1:0] >= `CFPSB_COMMON_BASE) ? 9'(a[OW-1:0]) : a;
  endfunction : map_common

  function automatic logic is_gpr(input logic [8:0] a);
    logic [1:0] bank;
    logic [OW-1:0] ofs;
    bank = a[8:OW];
    ofs = a[OW-1:0];
    return (ofs > `CFPSB_SFR_LAST) && ((bank < `CFPSB_BANK_2)
      || (ofs >= `CFPSB_COMMON_BASE)
      || (bank == `CFPSB_BANK_2 && ofs < `CFPSB_B2_GPR_END));
  endfunction : is_gpr

  cfpsb_phase_t phase;
  logic [PW-1:0] pc_r, pc_nxt, fetch_addr_r, stack_top;
  logic [13:0] instruction_holding_reg_r;
  logic instr_valid_r;
  logic [7:0] w_r, status_r, status_nxt, operand_r, result_r, wdata_r;
  logic [4:0] counter_upper_latch_r;
  logic [8:0] data_addr_r;
  logic data_rd_r, data_wr_r, sfr_sel_r, gpr_sel_r;
  logic hit_status_r, hit_low_r, hit_latch_r;
  logic res_z_r, res_nc_r, res_c_r;
  logic wait_r, run_r;
  logic [31:0] rdata_r;
  logic irq_ack_r, wdt_clear_r, sleep_r;

  cfpsb_phase_gen u_phase (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(run_r),
    .phase(phase)
  );

  // sequencing strobes, each the edge that ends the named phase
  wire logic at_q1 = run_r && phase == PHASE_ONE;
  wire logic at_q2 = run_r && phase == PHASE_TWO;
  wire logic at_q3 = run_r && phase == PHASE_THREE;
  wire logic at_q4 = run_r && phase == PHASE_FOUR;

  // decode
  wire logic [5:0] opc = instruction_holding_reg_r[13:8];
  wire logic [2:0] brc = instruction_holding_reg_r[13:11];
  wire logic [OW-1:0] fsel = instruction_holding_reg_r[OW-1:0];
  wire logic to_file = instruction_holding_reg_r[OW];
  wire logic [7:0] literal = instruction_holding_reg_r[7:0];
  wire logic special = opc == `CFPSB_OPC_SPECIAL && !to_file;
  cfpsb_op_t op;
  assign op = !instr_valid_r ? OP_NOP
    : brc == `CFPSB_BR_GOTO ? OP_GOTO
    : brc == `CFPSB_BR_CALL ? OP_CALL
    : opc[5:2] == `CFPSB_OPC_RETLIT ? OP_RETLIT
    : opc == `CFPSB_OPC_ADD ? OP_ADD
    : opc == `CFPSB_OPC_SUB ? OP_SUB
    : opc == `CFPSB_OPC_AND ? OP_AND
    : opc == `CFPSB_OPC_MOV ? OP_MOV
    : opc == `CFPSB_OPC_RRF ? OP_RRF
    : opc == `CFPSB_OPC_RLF ? OP_RLF
    : opc == `CFPSB_OPC_CLR && to_file ? OP_CLR
    : opc == `CFPSB_OPC_SPECIAL && to_file ? OP_MOVWF
    : special && fsel == `CFPSB_SP_RETURN ? OP_RET
    : special && fsel == `CFPSB_SP_RETINT ? OP_RETINT
    : special && fsel == `CFPSB_SP_SLEEP ? OP_SLEEP
    : special && fsel == `CFPSB_SP_WDCLR ? OP_WDCLR
    : OP_NOP;

  wire logic alu_op = op inside {OP_ADD, OP_SUB, OP_AND, OP_MOV, OP_RRF,
                                 OP_RLF};
  wire logic reads_file = alu_op;
  wire logic writes_file = (alu_op && to_file) || op == OP_CLR
    || op == OP_MOVWF;
  wire logic writes_w = (alu_op && !to_file) || op == OP_RETLIT;
  wire logic aff_z = op inside {OP_ADD, OP_SUB, OP_AND, OP_MOV, OP_CLR};
  wire logic aff_nc = op inside {OP_ADD, OP_SUB};
  wire logic aff_c = op inside {OP_ADD, OP_SUB, OP_RRF, OP_RLF};

  // direct: bank bits above the offset; indirect: bank bit above pointer
  wire logic [8:0] log_addr = (fsel == `CFPSB_A_INDIRECT)
    ? {status_r[`CFPSB_ST_IND], indirect_pointer} // [RQ11]
    : {status_r[`CFPSB_ST_BHI], status_r[`CFPSB_ST_BLO], fsel}; // [RQ8]
  wire logic [OW-1:0] log_ofs = log_addr[OW-1:0];

  // status, low byte and latch are decoded by offset alone
  wire logic hit_status = log_ofs == `CFPSB_A_STATUS; // [RQ18]
  wire logic hit_low = log_ofs == `CFPSB_A_CNT_LOW;
  wire logic hit_latch = log_ofs == `CFPSB_A_UP_LATCH;
  wire logic hit_any = hit_status || hit_low || hit_latch;
  wire logic hit_any_r = hit_status_r || hit_low_r || hit_latch_r;

  // the upper counter bits never reach the data path, only the low byte
  wire logic [7:0] operand_in = hit_status_r ? status_r
    : hit_low_r ? fetch_addr_r[7:0] // [RQ20]
    : hit_latch_r ? 8'(counter_upper_latch_r)
    : data_rdata;

  // alu
  wire logic [9:0] add_res = add_carry(operand_r, w_r, 1'b0);
  wire logic [9:0] sub_res = add_carry(operand_r, ~w_r, 1'b1); // [RQ17]
  wire logic [7:0] alu_val = op == OP_ADD ? add_res[7:0]
    : op == OP_SUB ? sub_res[7:0]
    : op == OP_AND ? (operand_r & w_r)
    : op == OP_MOV ? operand_r
    : op == OP_RRF ? {status_r[`CFPSB_ST_C], operand_r[7:1]}
    : op == OP_RLF ? {operand_r[6:0], status_r[`CFPSB_ST_C]}
    : op == OP_MOVWF ? w_r
    : op == OP_RETLIT ? literal
    : 8'h00;
  // nibble carry and carry are inverted borrows for subtract [RQ16]
  wire logic nc_val = op == OP_SUB ? sub_res[9] : add_res[9];
  wire logic c_val = op == OP_SUB ? sub_res[8]
    : op == OP_RRF ? operand_r[0] // [RQ17]
    : op == OP_RLF ? operand_r[7]
    : add_res[8];

  // flow changes
  wire logic commit = at_q4;
  wire logic branch_op = op inside {OP_GOTO, OP_CALL, OP_RET, OP_RETINT,
                                    OP_RETLIT};
  wire logic low_write = writes_file && hit_low_r;
  wire logic irq_take = commit && irq_req && !branch_op && !low_write;
  wire logic flush = commit && (branch_op || low_write || irq_take);
  wire logic do_push = commit && (op == OP_CALL || irq_take); // [RQ21]
  wire logic do_pop = commit && op inside {OP_RET, OP_RETINT, OP_RETLIT};

  cfpsb_ret_stack #(
    .DEPTH(8),
    .AW(3),
    .DW(PW)
  ) u_stack (
    .sys_clk(sys_clk),
    .reset(reset),
    .push(do_push),
    .pop(do_pop),
    .push_data(fetch_addr_r),
    .top_data(stack_top)
  );

  always_comb
  begin
    pc_nxt = pc_r;
    if (at_q1)
      pc_nxt = pc_r + PW'(1); // [RQ2]
    else if (irq_take)
      pc_nxt = `CFPSB_IRQ_VECTOR; // [RQ7]
    else if (commit && (op == OP_GOTO || op == OP_CALL))
      pc_nxt = {counter_upper_latch_r[4:3],
                instruction_holding_reg_r[10:0]}; // [RQ19]
    else if (commit && low_write)
      pc_nxt = {counter_upper_latch_r, result_r}; // [RQ19]
    else if (do_pop)
      pc_nxt = stack_top; // [RQ21]
  end

  // bus side
  wire logic bus_first = (avs_read || avs_write) && wait_r;
  wire logic bus_wr = avs_write && !wait_r;
  wire logic [1:0] bus_idx = avs_address[3:2];
  wire logic bus_wr_status = bus_wr && bus_idx == `CFPSB_REG_STATUS;
  wire logic [31:0] bus_mux = bus_idx == `CFPSB_REG_CTRL ? 32'(run_r)
    : bus_idx == `CFPSB_REG_PC ? 32'(pc_r)
    : bus_idx == `CFPSB_REG_W ? 32'(w_r)
    : 32'(status_r);

  always_comb
  begin
    status_nxt = status_r;
    if (bus_wr_status && !commit)
    begin
      status_nxt[7:5] = avs_writedata[7:5];
      status_nxt[2:0] = avs_writedata[2:0];
    end
    if (commit && writes_file && hit_status_r)
    begin
      status_nxt[7:5] = result_r[7:5];
      if (!(aff_z || aff_nc || aff_c))
        status_nxt[2:0] = result_r[2:0]; // [RQ12]
    end
    if (commit && aff_z)
      status_nxt[`CFPSB_ST_Z] = res_z_r; // [RQ15]
    if (commit && aff_nc)
      status_nxt[`CFPSB_ST_NC] = res_nc_r; // [RQ16]
    if (commit && aff_c)
      status_nxt[`CFPSB_ST_C] = res_c_r; // [RQ17]
    if (commit && op inside {OP_SLEEP, OP_WDCLR})
      status_nxt[`CFPSB_ST_TMO] = 1'b1; // [RQ13]
    if (commit && op == OP_WDCLR)
      status_nxt[`CFPSB_ST_PWD] = 1'b1; // [RQ14]
    if (commit && op == OP_SLEEP)
      status_nxt[`CFPSB_ST_PWD] = 1'b0; // [RQ14]
    if (wdt_timeout)
      status_nxt[`CFPSB_ST_TMO] = 1'b0; // [RQ13]
  end

  // counter and status; a power-up reset also sets both reset flags
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pc_r <= `CFPSB_PC_RESET; // [RQ20]
      status_r <= `CFPSB_STATUS_RST; // [RQ13] [RQ14]
    end
    else
    begin
      pc_r <= pc_nxt;
      status_r <= status_nxt;
    end
  end

  // fetch address wraps into the implemented region [RQ6] [RQ5]
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      fetch_addr_r <= `CFPSB_PC_RESET;
    else if (at_q1)
      fetch_addr_r <= pc_r & PMASK;
  end

  // a flushed word executes as a no-operation [RQ3]
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      instruction_holding_reg_r <= '0;
      instr_valid_r <= 1'b0;
    end
    else if (at_q4)
    begin
      instruction_holding_reg_r <= prog_rdata; // [RQ2]
      instr_valid_r <= !flush; // [RQ3]
    end
  end

  // data access: address in phase one, read phase two, write phase four
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      data_addr_r <= '0;
      data_rd_r <= 1'b0;
      sfr_sel_r <= 1'b0;
      gpr_sel_r <= 1'b0;
      hit_status_r <= 1'b0;
      hit_low_r <= 1'b0;
      hit_latch_r <= 1'b0;
    end
    else if (at_q1)
    begin
      data_addr_r <= map_common(log_addr); // [RQ10]
      data_rd_r <= reads_file && !hit_any; // [RQ4]
      sfr_sel_r <= log_ofs <= `CFPSB_SFR_LAST; // [RQ9]
      gpr_sel_r <= is_gpr(log_addr); // [RQ9]
      hit_status_r <= hit_status;
      hit_low_r <= hit_low;
      hit_latch_r <= hit_latch;
    end
    else if (at_q2)
      data_rd_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      operand_r <= '0;
    else if (at_q2)
      operand_r <= operand_in; // [RQ4]
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      result_r <= '0;
      wdata_r <= '0;
      data_wr_r <= 1'b0;
      res_z_r <= 1'b0;
      res_nc_r <= 1'b0;
      res_c_r <= 1'b0;
    end
    else if (at_q3)
    begin
      result_r <= alu_val;
      wdata_r <= alu_val;
      data_wr_r <= writes_file && !hit_any_r; // [RQ4]
      res_z_r <= alu_val == 8'h00; // [RQ15]
      res_nc_r <= nc_val;
      res_c_r <= c_val;
    end
    else if (at_q4)
      data_wr_r <= 1'b0;
  end

  // the latch is untouched by push and pop [RQ21]
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      w_r <= '0;
      counter_upper_latch_r <= '0;
    end
    else if (commit)
    begin
      if (writes_w)
        w_r <= result_r;
      if (writes_file && hit_latch_r)
        counter_upper_latch_r <= result_r[4:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      irq_ack_r <= 1'b0;
      wdt_clear_r <= 1'b0;
      sleep_r <= 1'b0;
    end
    else
    begin
      irq_ack_r <= irq_take;
      wdt_clear_r <= commit && op == OP_WDCLR;
      sleep_r <= commit && op == OP_SLEEP;
    end
  end

  // one wait cycle: the read word is sampled as waitrequest falls
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      run_r <= `CFPSB_CTRL_RST;
    end
    else
    begin
      wait_r <= !bus_first;
      if (bus_first && avs_read)
        rdata_r <= bus_mux;
      if (bus_wr && bus_idx == `CFPSB_REG_CTRL)
        run_r <= avs_writedata[`CFPSB_CTRL_RUN];
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign prog_addr = fetch_addr_r;
  assign data_addr = data_addr_r;
  assign data_rd = data_rd_r;
  assign data_wr = data_wr_r;
  assign data_wdata = wdata_r;
  assign data_sfr_sel = sfr_sel_r;
  assign data_gpr_sel = gpr_sel_r;
  assign irq_ack = irq_ack_r;
  assign wdt_clear = wdt_clear_r;
  assign sleep_req = sleep_r;
  assign cur_phase = phase;

  a_phase_wrap: // phase four returns to phase one [RQ1]
    assert property (@(posedge sys_clk) disable iff (reset)
      at_q4 |=> phase == PHASE_ONE)
    else $error("phase did not wrap after phase four");

  a_pc_step: // counter steps by one in phase one [RQ2]
    assert property (@(posedge sys_clk) disable iff (reset)
      at_q1 |=> pc_r == $past(pc_r) + PW'(1)
        && fetch_addr_r == ($past(pc_r) & PMASK))
    else $error("counter did not advance in phase one");

  a_flush_taken: // branch discards prefetched word [RQ3]
    assert property (@(posedge sys_clk) disable iff (reset)
      commit && branch_op |=> !instr_valid_r ##4 instr_valid_r)
    else $error("branch did not take two cycles");

  a_read_phase: // operand read only in phase two [RQ4]
    assert property (@(posedge sys_clk) disable iff (reset)
      data_rd |-> phase == PHASE_TWO)
    else $error("data read outside phase two");

  a_write_phase: // destination write only in phase four [RQ4]
    assert property (@(posedge sys_clk) disable iff (reset)
      $rose(data_wr) |-> phase == PHASE_FOUR && $past(at_q3))
    else $error("data write outside phase four");

  a_fetch_wrap: // fetch stays inside implemented memory [RQ6]
    assert property (@(posedge sys_clk) disable iff (reset)
      (fetch_addr_r & ~PMASK) == '0)
    else $error("fetch address beyond implemented memory");

  a_reset_start: // counter zero after reset [RQ20]
    assert property (@(posedge sys_clk) disable iff (reset)
      $fell(reset) |-> pc_r == `CFPSB_PC_RESET
        && status_r == `CFPSB_STATUS_RST)
    else $error("counter or status not cleared by reset");

  a_irq_vector: // accepted interrupt goes to vector [RQ7]
    assert property (@(posedge sys_clk) disable iff (reset)
      irq_take |=> pc_r == `CFPSB_IRQ_VECTOR && irq_ack ##1 !irq_ack)
    else $error("interrupt did not vector to address four");

  a_common_ram: // mirrored window lands in bank zero [RQ10]
    assert property (@(posedge sys_clk) disable iff (reset)
      data_addr_r[OW-1:0] >= `CFPSB_COMMON_BASE |-> data_addr_r[8:OW] == 2'h0)
    else $error("common ram not mapped to bank zero");

  a_sleep_flags: // sleep sets timeout and clears power-down [RQ14]
    assert property (@(posedge sys_clk) disable iff (reset)
      commit && op == OP_SLEEP && !wdt_timeout |=>
        status_r[`CFPSB_ST_TMO] && !status_r[`CFPSB_ST_PWD] && sleep_req)
    else $error("sleep did not update reset flags");

  a_timeout_clr: // watchdog timeout clears timeout flag [RQ13]
    assert property (@(posedge sys_clk) disable iff (reset)
      wdt_timeout |=> !status_r[`CFPSB_ST_TMO])
    else $error("timeout flag not cleared by watchdog");

endmodule : cfpsb_core
`default_nettype wire

/* File: bench/cfpsb_mem_model.sv */
/*
  partner: program memory and banked data file of the core.
  assumes the bench loads the program before reset is released.
*/
`timescale 1ns/10ps
`default_nettype none
module cfpsb_mem_model
(
  // clock
  input wire logic sys_clk,
  // program memory
  input wire logic [12:0] prog_addr,
  output logic [13:0] prog_rdata,
  // data file
  input wire logic [8:0] data_addr,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata
);
  logic [13:0] rom [0:1023];
  logic [7:0] ram [0:511];
  logic [7:0] last_r;
  initial foreach (rom[i]) rom[i] = 14'h0000;
  // only 1K words exist, so high address bits are not decoded
  assign prog_rdata = rom[prog_addr[9:0]];
  // idle bus shows the inverse, so a late sample cannot pass by luck
  assign data_rdata = data_rd ? ram[data_addr] : ~last_r;
  always_ff @(posedge sys_clk)
  begin
    if (data_wr)
      ram[data_addr] <= data_wdata;
    if (data_rd)
      last_r <= ram[data_addr];
  end
endmodule : cfpsb_mem_model
`default_nettype wire

/* File: bench/cfpsb_core_tb_top.sv */
/*
  self-checking bench of the core control block.
  assumes the memory model stands on the far side of the core.
*/
`timescale 1ns/10ps
`default_nettype none
module cfpsb_core_tb_top
  import cfpsb_pkg::*;
;
  logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, wdt;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, seed;
  logic [12:0] prog_addr;
  logic [13:0] prog_rdata;
  logic [8:0] data_addr;
  logic data_rd, data_wr, sfr_sel, gpr_sel;
  logic [7:0] data_wdata, data_rdata, v;
  cfpsb_phase_t cur_phase, ph_prev;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [12:0] exp_pc [0:11] = '{13'h0000, 13'h0001, 13'h0004, 13'h0005,
    13'h0006, 13'h0001, 13'h0002, 13'h03F0, 13'h03F1, 13'h03F2, 13'h03F3,
    13'h03F0};
  cfpsb_core #(.PMEM_AW(10)) i_cfpsb_core (.sys_clk(sys_clk),
    .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata), .data_addr(data_addr),
    .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .indirect_pointer(8'h00),
    .data_sfr_sel(sfr_sel), .data_gpr_sel(gpr_sel), .irq_req(1'b0),
    .wdt_timeout(wdt), .irq_ack(), .wdt_clear(), .sleep_req(),
    .cur_phase(cur_phase));
  cfpsb_mem_model i_cfpsb_mem_model (.sys_clk(sys_clk),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata), .data_addr(data_addr),
    .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rdata(data_rdata));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // waits at falling edges, bounded, for a wanted state
  task automatic wait_for(input logic ph, input cfpsb_phase_t p);
    int i;
    for (i = 0; i < 60; i++)
    begin
      @(negedge sys_clk);
      if (ph ? cur_phase === p : data_wr === 1'b1)
        return;
    end
    n_mismatch++;
    give_verdict();
  endtask : wait_for
  // bus access starts in phase four, so it never commits in phase four
  task automatic bus(input logic wr, input logic [3:0] a, logic [31:0] d);
    int i;
    wait_for(1'b1, PHASE_THREE);
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask : bus
  // the phase seen last stays at phase four through reset
  always @(negedge sys_clk)
  begin
    if (reset)
      ph_prev = PHASE_FOUR;
    else
    begin
      chk("phase", cur_phase, 2'(ph_prev + 1));
      ph_prev = cur_phase;
    end
  end
  initial
  begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    wdt = 1'b0;
    seed = 32'h5067;
    #1;
    i_cfpsb_mem_model.rom[0] = 14'h2004;
    i_cfpsb_mem_model.rom[1] = 14'h2FF0;
    i_cfpsb_mem_model.rom[4] = 14'h0063;
    i_cfpsb_mem_model.rom[5] = 14'h0008;
    i_cfpsb_mem_model.rom[10'h3F0] = 14'h00A5;
    i_cfpsb_mem_model.rom[10'h3F1] = 14'h00F5;
    i_cfpsb_mem_model.rom[10'h3F2] = 14'h2BF0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    // call, sleep, return, wrapping jump: flushed fetches cost a cycle each
    for (int k = 0; k < 12; k++)
    begin
      wait_for(1'b1, PHASE_TWO);
      chk("fetch", prog_addr, exp_pc[k]);
    end
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk("status sleep", q, 32'h0000_0010);
    // one watchdog timeout pulse clears the timeout flag for the rest
    wdt <= 1'b1;
    @(posedge sys_clk);
    wdt <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      v = seed[7:0];
      v[6:5] = 2'(k);
      bus(1'b1, 4'hC, {seed[31:8], v});
      bus(1'b0, 4'hC, 32'h0000_0000);
      chk("status", q, {24'h00_0000, v[7:5], 2'b00, v[2:0]});
      wait_for(1'b0, PHASE_ONE);
      repeat (2)
      begin
        wait_for(1'b0, PHASE_ONE);
        chk("wr phase", cur_phase, PHASE_FOUR);
        chk("wr data", data_wdata, 8'h00);
        // offset 25h of bank three lies outside every RAM range
        chk("gpr", {sfr_sel, gpr_sel}, {1'b0,
          data_addr[6:0] == 7'h75 || v[6:5] != 2'h3});
        if (data_addr[6:0] == 7'h75)
          chk("common", data_addr, 9'h075);
        else
          chk("bank", data_addr, {v[6:5], 7'h25});
      end
    end
    give_verdict();
  end
endmodule : cfpsb_core_tb_top
`default_nettype wire
